// File: logic/uhp_pkg.sv
// What this block does
// [R1] Host drives select low for any access
// [R2] Address line high picks control/status, low data
// [R3] Read strobe low drives addressed location out
// [R4] Write strobe low stores bus into location
// [R5] Deselected device keeps data bus undriven
// [R6] Data address: read receive, write transmit buffer
// [R7] Control address: read status, write control
// [R8] Control codes held apart from transmit buffer
// [R9] Host transfers use eight-bit two-way bus
// [R10] Data-set-ready only shows in one status bit; the code also gates transmit on it
// [R11] Terminal-ready output follows host control writes
// [R12] Transmit only with both readies low, request-to-send
// [R13] Half-duplex modem answers clear-to-send after 2 ms; the test modem answers after CTS_DELAY (8) clock cycles
// [R14] Full-duplex link returns request as clear-to-send
// [R15] Finished shifter takes buffer, raises transmit-ready
// [R16] Transmit-ready holds until next host data write
// [R17] Transmit-ready also readable as status bit
// [R18] Shift-empty rises when shifter finishes its byte
// [R19] Receiver-ready goes low with framed character waiting
// [R20] External sync: far end gives rising sync edge
// [R21] Internal sync: sync pin driven high on pattern
// [R22] Reset leaves device idle, no transmit or receive
// [R23] Shift-empty holds until buffer enters shifter
// [R24] Receive read clears receiver-ready; also status bit
// [R25] Host never strobes read and write together
package uhp_pkg;
	localparam int DATA_W = 8;
	// ----------------------------------------------------------------
	// Synchroniser lanes of the pin inputs
	// ----------------------------------------------------------------
	localparam int PIN_N = 10;
	localparam int PIN_CS_N = 0;
	localparam int PIN_CD = 1;
	localparam int PIN_RD_N = 2;
	localparam int PIN_WR_N = 3;
	localparam int PIN_DSR_N = 4;
	localparam int PIN_CTS_N = 5;
	localparam int PIN_TXC = 6;
	localparam int PIN_RXC = 7;
	localparam int PIN_RXD = 8;
	localparam int PIN_SYNC = 9;
	localparam logic [PIN_N-1:0] PIN_RESET = 10'h3FF;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_TX_EN = 0;
	localparam int CTL_DTR = 1;
	localparam int CTL_RX_EN = 2;
	localparam int CTL_SYNC_MODE = 3;
	localparam int CTL_EXT_SYNC = 4;
	localparam int CTL_RTS = 5;
	localparam int CTL_ERR_CLR = 6;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Status word fields
	// ----------------------------------------------------------------
	localparam int STS_TX_READY = 0;
	localparam int STS_RX_READY = 1;
	localparam int STS_TX_EMPTY = 2;
	localparam int STS_FRAME_ERR = 3;
	localparam int STS_OVERRUN = 4;
	localparam int STS_SYNC = 6;
	localparam int STS_DSR = 7;
	// ----------------------------------------------------------------
	// Serial framing counts
	// ----------------------------------------------------------------
	localparam logic [3:0] ASYNC_BITS = 4'hA;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [3:0] CHAR_BITS = 4'h8;
	localparam logic [7:0] SYNC_PATTERN_DEF = 8'h69;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_DATA = 2'b01,
		RX_STOP = 2'b10,
		RX_HUNT = 2'b11
	} uhp_rx_state_type;
endpackage

// File: logic/uhp_tx_shift.sv
`timescale 1ns/1ps
`default_nettype none
module uhp_tx_shift (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic load,
	input wire logic sync_mode,
	input wire logic [7:0] load_data,
	output logic txd,
	output logic empty
);
	typedef struct packed {
		logic [9:0] shift;
		logic [3:0] cnt;
		logic txd;
	} uhp_txs_type;
	uhp_txs_type s_reg;
	uhp_txs_type s_next;

	always_comb begin
		s_next = s_reg;
		if (load) begin
			// Async frame carries start and stop bits; sync sends bare data
			if (sync_mode) begin
				s_next.shift = {2'b11, load_data};
				s_next.cnt = uhp_pkg::SYNC_BITS;
			end else begin
				s_next.shift = {1'b1, load_data, 1'b0};
				s_next.cnt = uhp_pkg::ASYNC_BITS;
			end
		end else if (tick && s_reg.cnt != 4'h0) begin
			s_next.txd = s_reg.shift[0];
			s_next.shift = {1'b1, s_reg.shift[9:1]};
			s_next.cnt = s_reg.cnt - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '{shift: 10'h3FF, cnt: 4'h0, txd: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end

	assign txd = s_reg.txd;
	assign empty = (s_reg.cnt == 4'h0); // [R18] [R23]
endmodule
`default_nettype wire

// File: logic/uhp_usart.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module uhp_usart #(
	parameter logic [7:0] SYNC_PATTERN = uhp_pkg::SYNC_PATTERN_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic cd,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_n,
	input wire logic dsr_n,
	input wire logic cts_n,
	output logic dtr_n,
	output logic rts_n,
	input wire logic tx_bit_clock,
	input wire logic rx_bit_clock,
	input wire logic rx_data,
	output logic tx_data,
	output logic tx_buffer_ready,
	output logic tx_shift_empty,
	output logic rx_char_ready_n,
	input wire logic sync_found_in,
	output logic sync_found_out,
	output logic sync_found_oe_n
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [uhp_pkg::PIN_N-1:0] p1;
		logic [uhp_pkg::PIN_N-1:0] p2;
		logic [uhp_pkg::PIN_N-1:0] p3;
		logic [7:0] d1;
		logic [7:0] d2;
		logic [7:0] wdat;
		logic [7:0] ctrl;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [7:0] rx_buf;
		logic rx_full;
		logic overrun;
		logic frame_err;
		logic [7:0] rx_shift;
		logic [3:0] rx_cnt;
		uhp_pkg::uhp_rx_state_type rx_state;
		logic sync_det;
		logic [7:0] dout;
	} uhp_state_type;
	uhp_state_type s_reg;
	uhp_state_type s_next;

	logic [uhp_pkg::PIN_N-1:0] pins;
	logic tx_empty;
	logic tx_load;
	logic tx_tick;

	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction

	assign pins = {sync_found_in, rx_data, rx_bit_clock, tx_bit_clock, cts_n, dsr_n,
		wr_n, rd_n, cd, cs_n};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic sel;
	logic rd_end;
	logic wr_end;
	logic rx_tick;
	logic [7:0] rx_sh;
	logic link_ok;
	logic [7:0] status;

	always_comb begin
		s_next = s_reg;
		s_next.p1 = pins;
		s_next.p2 = s_reg.p1;
		s_next.p3 = s_reg.p2;
		s_next.d1 = host_data_in;
		s_next.d2 = s_reg.d1;
		// Select and address are taken as they stood while the strobe was low
		sel = !s_reg.p3[uhp_pkg::PIN_CS_N]; // [R1]
		// Both strobes low at once is dropped as a bad access
		rd_end = rise(s_reg.p2[uhp_pkg::PIN_RD_N], s_reg.p3[uhp_pkg::PIN_RD_N])
			&& s_reg.p3[uhp_pkg::PIN_WR_N] && sel; // [R25]
		wr_end = rise(s_reg.p2[uhp_pkg::PIN_WR_N], s_reg.p3[uhp_pkg::PIN_WR_N])
			&& s_reg.p3[uhp_pkg::PIN_RD_N] && sel; // [R25]
		rx_tick = rise(s_reg.p2[uhp_pkg::PIN_RXC], s_reg.p3[uhp_pkg::PIN_RXC]);
		rx_sh = {s_reg.p2[uhp_pkg::PIN_RXD], s_reg.rx_shift[7:1]};
		// Write data is held while the strobe is low, since the bus may move after it rises
		if (!s_reg.p2[uhp_pkg::PIN_WR_N]) begin
			s_next.wdat = s_reg.d2;
		end

		// ------------------------------------------------------------
		// Host writes
		// ------------------------------------------------------------
		if (wr_end) begin
			if (s_reg.p3[uhp_pkg::PIN_CD]) begin // [R2]
				s_next.ctrl = s_reg.wdat; // [R4] [R7] [R8] [R11]
			end else begin
				s_next.tx_buf = s_reg.wdat; // [R4] [R6]
			end
		end

		// ------------------------------------------------------------
		// Transmit buffer hand-over
		// ------------------------------------------------------------
		if (tx_load) begin
			s_next.tx_full = 1'b0; // [R15]
		end
		if (wr_end && !s_reg.p3[uhp_pkg::PIN_CD]) begin
			s_next.tx_full = 1'b1; // [R16]
		end

		// ------------------------------------------------------------
		// Receiver
		// ------------------------------------------------------------
		if (rd_end && !s_reg.p3[uhp_pkg::PIN_CD]) begin
			s_next.rx_full = 1'b0; // [R24]
		end
		if (wr_end && s_reg.p3[uhp_pkg::PIN_CD] && s_reg.wdat[uhp_pkg::CTL_ERR_CLR]) begin
			s_next.overrun = 1'b0;
			s_next.frame_err = 1'b0;
		end
		if (!s_reg.ctrl[uhp_pkg::CTL_RX_EN]) begin
			s_next.rx_state = s_reg.ctrl[uhp_pkg::CTL_SYNC_MODE] ?
				uhp_pkg::RX_HUNT : uhp_pkg::RX_IDLE;
			s_next.sync_det = 1'b0;
		end else if (s_reg.ctrl[uhp_pkg::CTL_SYNC_MODE]) begin
			if (s_reg.ctrl[uhp_pkg::CTL_EXT_SYNC]
				&& rise(s_reg.p2[uhp_pkg::PIN_SYNC], s_reg.p3[uhp_pkg::PIN_SYNC])) begin
				// Framing restarts from the next sampled bit
				s_next.rx_state = uhp_pkg::RX_DATA; // [R20]
				s_next.rx_cnt = 4'h0;
			end else if (rx_tick) begin
				s_next.rx_shift = rx_sh;
				if (!s_reg.ctrl[uhp_pkg::CTL_EXT_SYNC]) begin
					s_next.sync_det = (rx_sh == SYNC_PATTERN); // [R21]
				end
				case (s_reg.rx_state)
					uhp_pkg::RX_HUNT: begin
						if (!s_reg.ctrl[uhp_pkg::CTL_EXT_SYNC] && rx_sh == SYNC_PATTERN) begin
							s_next.rx_state = uhp_pkg::RX_DATA;
							s_next.rx_cnt = 4'h0;
						end
					end
					uhp_pkg::RX_DATA: begin
						s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
						if (s_reg.rx_cnt == uhp_pkg::CHAR_BITS - 4'h1) begin
							s_next.rx_cnt = 4'h0;
							s_next.rx_buf = rx_sh;
							s_next.rx_full = 1'b1; // [R19]
							s_next.overrun = s_reg.overrun | s_reg.rx_full;
						end
					end
					default: begin
						s_next.rx_state = uhp_pkg::RX_HUNT;
					end
				endcase
			end
		end else if (rx_tick) begin
			case (s_reg.rx_state)
				uhp_pkg::RX_IDLE: begin
					if (!s_reg.p2[uhp_pkg::PIN_RXD]) begin
						s_next.rx_state = uhp_pkg::RX_DATA;
						s_next.rx_cnt = 4'h0;
					end
				end
				uhp_pkg::RX_DATA: begin
					s_next.rx_shift = rx_sh;
					s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
					if (s_reg.rx_cnt == uhp_pkg::CHAR_BITS - 4'h1) begin
						s_next.rx_state = uhp_pkg::RX_STOP;
					end
				end
				uhp_pkg::RX_STOP: begin
					s_next.rx_state = uhp_pkg::RX_IDLE;
					if (s_reg.p2[uhp_pkg::PIN_RXD]) begin
						s_next.rx_buf = s_reg.rx_shift;
						s_next.rx_full = 1'b1; // [R19]
						s_next.overrun = s_reg.overrun | s_reg.rx_full;
					end else begin
						s_next.frame_err = 1'b1;
					end
				end
				default: begin
					s_next.rx_state = uhp_pkg::RX_IDLE;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Read data, kept current for whichever location is addressed
		// ------------------------------------------------------------
		status = 8'h00;
		status[uhp_pkg::STS_TX_READY] = !s_reg.tx_full; // [R17]
		status[uhp_pkg::STS_RX_READY] = s_reg.rx_full; // [R24]
		status[uhp_pkg::STS_TX_EMPTY] = tx_empty;
		status[uhp_pkg::STS_FRAME_ERR] = s_reg.frame_err;
		status[uhp_pkg::STS_OVERRUN] = s_reg.overrun;
		status[uhp_pkg::STS_SYNC] = s_reg.sync_det;
		status[uhp_pkg::STS_DSR] = !s_reg.p2[uhp_pkg::PIN_DSR_N]; // [R10]
		s_next.dout = s_reg.p2[uhp_pkg::PIN_CD] ? status : s_reg.rx_buf; // [R3] [R6] [R7]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			// Receiver and transmitter both idle, control cleared
			s_reg <= '{p1: uhp_pkg::PIN_RESET, p2: uhp_pkg::PIN_RESET,
				p3: uhp_pkg::PIN_RESET, d1: 8'h00, d2: 8'h00, wdat: 8'h00,
				ctrl: uhp_pkg::CTL_RESET, tx_buf: 8'h00, tx_full: 1'b0,
				rx_buf: 8'h00, rx_full: 1'b0, overrun: 1'b0, frame_err: 1'b0,
				rx_shift: 8'h00, rx_cnt: 4'h0, rx_state: uhp_pkg::RX_IDLE,
				sync_det: 1'b0, dout: 8'h00}; // [R22]
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	// Sending needs both readies and the modem's clear-to-send low
	assign link_ok = !s_reg.p2[uhp_pkg::PIN_DSR_N] && s_reg.ctrl[uhp_pkg::CTL_DTR]
		&& s_reg.ctrl[uhp_pkg::CTL_RTS] && !s_reg.p2[uhp_pkg::PIN_CTS_N]; // [R12]
	assign tx_load = tx_empty && s_reg.tx_full && s_reg.ctrl[uhp_pkg::CTL_TX_EN]
		&& link_ok; // [R15]
	assign tx_tick = rise(s_reg.p3[uhp_pkg::PIN_TXC], s_reg.p2[uhp_pkg::PIN_TXC]);

	uhp_tx_shift u_tx (
		.clk(clk),
		.nrst(nrst),
		.tick(tx_tick),
		.load(tx_load),
		.sync_mode(s_reg.ctrl[uhp_pkg::CTL_SYNC_MODE]),
		.load_data(s_reg.tx_buf),
		.txd(tx_data),
		.empty(tx_empty)
	);

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	// Bus drive follows the synchronised strobes, so it lags the pins by two cycles
	assign host_data_oe_n = s_reg.p2[uhp_pkg::PIN_CS_N] || s_reg.p2[uhp_pkg::PIN_RD_N]
		|| !s_reg.p2[uhp_pkg::PIN_WR_N]; // [R3] [R5] [R9]
	assign host_data_out = s_reg.dout; // [R9]
	assign dtr_n = !s_reg.ctrl[uhp_pkg::CTL_DTR]; // [R11]
	assign rts_n = !s_reg.ctrl[uhp_pkg::CTL_RTS]; // [R12]
	assign tx_buffer_ready = !s_reg.tx_full; // [R15] [R16]
	assign tx_shift_empty = tx_empty; // [R18]
	assign rx_char_ready_n = !s_reg.rx_full; // [R19]
	assign sync_found_out = s_reg.sync_det; // [R21]
	assign sync_found_oe_n = !(s_reg.ctrl[uhp_pkg::CTL_SYNC_MODE]
		&& !s_reg.ctrl[uhp_pkg::CTL_EXT_SYNC]); // [R20] [R21]
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0] ctl;
		logic dsr;
		logic dtr_n;
		logic rts_n;
		logic [7:0] sts;
	} uhp_row_type;
	localparam uhp_row_type ROWS [4] = '{'{8'h00, 1'b0, 1'b1, 1'b1, 8'h05},
		'{8'h02, 1'b1, 1'b0, 1'b1, 8'h85}, '{8'h20, 1'b1, 1'b1, 1'b0, 8'h85},
		'{8'h22, 1'b0, 1'b0, 1'b0, 8'h05}};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cs_n = 1'b1;
	logic cd = 1'b0;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [7:0] host_data_in = 8'h00;
	logic dsr_on = 1'b0;
	logic sync_found_in = 1'b0;
	logic [7:0] host_data_out;
	logic [7:0] q;
	logic host_data_oe_n, dsr_n, cts_n, dtr_n, rts_n, bit_clock, rx_data, tx_data;
	logic tx_buffer_ready, tx_shift_empty, rx_char_ready_n, oe_seen;
	logic sync_found_out, sync_found_oe_n;
	logic [7:0] idle_pins;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	always #2.5 clk = ~clk;
	uhp_usart i_dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .cd(cd), .rd_n(rd_n), .wr_n(wr_n),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe_n(host_data_oe_n), .dsr_n(dsr_n), .cts_n(cts_n), .dtr_n(dtr_n),
		.rts_n(rts_n), .tx_bit_clock(bit_clock), .rx_bit_clock(bit_clock), .rx_data(rx_data),
		.tx_data(tx_data), .tx_buffer_ready(tx_buffer_ready), .tx_shift_empty(tx_shift_empty),
		.rx_char_ready_n(rx_char_ready_n), .sync_found_in(sync_found_in),
		.sync_found_out(sync_found_out), .sync_found_oe_n(sync_found_oe_n));
	assign idle_pins = {sync_found_oe_n, host_data_oe_n, dtr_n, rts_n, tx_data,
		tx_buffer_ready, tx_shift_empty, rx_char_ready_n};
	uhp_modem i_modem (.clk(clk), .nrst(nrst), .dsr_on(dsr_on), .rts_n(rts_n),
		.tx_data(tx_data), .dsr_n(dsr_n), .cts_n(cts_n), .bit_clock(bit_clock),
		.rx_data(rx_data));
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic chk1(input string name, input logic exp, input logic got);
		chk8(name, {7'h00, exp}, {7'h00, got});
	endtask
	// Strobes held five cycles, as the pin synchronisers need two
	task automatic access(input logic c, input logic r, input logic w, input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		cd <= c;
		rd_n <= !r;
		wr_n <= !w;
		host_data_in <= d;
		repeat (4) @(posedge clk);
		@(negedge clk);
		q = host_data_out;
		oe_seen = host_data_oe_n;
		@(posedge clk);
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge clk);
		cs_n <= 1'b1;
		host_data_in <= ~d;
		repeat (3) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk8("idle pins", 8'hFF, idle_pins);
		foreach (ROWS[i]) begin
			@(posedge clk);
			dsr_on <= ROWS[i].dsr;
			access(1'b1, 1'b0, 1'b1, ROWS[i].ctl);
			access(1'b1, 1'b1, 1'b0, 8'h00);
			chk8("status", ROWS[i].sts, q);
			chk1("dtr_n", ROWS[i].dtr_n, dtr_n);
			chk1("rts_n", ROWS[i].rts_n, rts_n);
		end
		@(posedge clk);
		rd_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk1("oe_n", 1'b1, host_data_oe_n);
		rd_n <= 1'b1;
		access(1'b0, 1'b1, 1'b1, 8'h5A);
		chk1("oe_n", 1'b1, oe_seen);
		chk1("tx_ready", 1'b1, tx_buffer_ready);
		access(1'b0, 1'b0, 1'b1, 8'hA5);
		chk1("tx_ready", 1'b0, tx_buffer_ready);
		dsr_on <= 1'b1;
		access(1'b1, 1'b0, 1'b1, 8'h27);
		for (n = 0; n < 200 && tx_buffer_ready !== 1'b1; n++) @(posedge clk);
		@(negedge clk);
		chk1("tx_empty", 1'b0, tx_shift_empty);
		access(1'b0, 1'b0, 1'b1, 8'h3C);
		chk1("tx_ready", 1'b0, tx_buffer_ready);
		for (n = 0; n < 1000 && rx_char_ready_n !== 1'b0; n++) @(posedge clk);
		access(1'b0, 1'b1, 1'b0, 8'h00);
		chk8("rx data", 8'hA5, q);
		chk1("rx_ready_n", 1'b1, rx_char_ready_n);
		for (n = 0; n < 1000 && tx_shift_empty !== 1'b1; n++) @(posedge clk);
		for (n = 0; n < 1000 && rx_char_ready_n !== 1'b0; n++) @(posedge clk);
		chk1("tx_empty", 1'b1, tx_shift_empty);
		access(1'b1, 1'b1, 1'b0, 8'h00);
		chk8("status", 8'h87, q);
		access(1'b0, 1'b1, 1'b0, 8'h00);
		chk8("rx data", 8'h3C, q);
		access(1'b1, 1'b1, 1'b0, 8'h00);
		chk8("status", 8'h85, q);
		// Internal sync: the pattern aligns framing of the next character
		access(1'b1, 1'b0, 1'b1, 8'h2F);
		access(1'b0, 1'b0, 1'b1, uhp_pkg::SYNC_PATTERN_DEF);
		access(1'b0, 1'b0, 1'b1, 8'hC3);
		for (n = 0; n < 1000 && sync_found_out !== 1'b1; n++) @(posedge clk);
		@(negedge clk);
		chk1("sync_found", 1'b1, sync_found_out);
		chk1("sync_oe_n", 1'b0, sync_found_oe_n);
		for (n = 0; n < 1000 && rx_char_ready_n !== 1'b0; n++) @(posedge clk);
		@(negedge clk);
		chk1("rx_ready_n", 1'b0, rx_char_ready_n);
		access(1'b0, 1'b1, 1'b0, 8'h00);
		chk8("rx data", 8'hC3, q);
		// External sync: nothing is framed until the far end gives its edge
		access(1'b1, 1'b0, 1'b1, 8'h68);
		access(1'b1, 1'b0, 1'b1, 8'h3C);
		repeat (400) @(posedge clk);
		access(1'b1, 1'b1, 1'b0, 8'h00);
		chk8("status", 8'h85, q);
		chk1("sync_oe_n", 1'b1, sync_found_oe_n);
		sync_found_in <= 1'b1;
		repeat (60) @(posedge clk);
		sync_found_in <= 1'b0;
		for (n = 0; n < 1000 && rx_char_ready_n !== 1'b0; n++) @(posedge clk);
		@(negedge clk);
		chk1("rx_ready_n", 1'b0, rx_char_ready_n);
		access(1'b0, 1'b1, 1'b0, 8'h00);
		chk8("rx data", 8'hFF, q);
		// Reset in mid-run drops the link and returns every pin to idle
		@(posedge clk);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk8("idle pins", 8'hFF, idle_pins);
		finish_test();
	end
endmodule
`default_nettype wire

// File: verif/uhp_modem.sv
`timescale 1ns/1ps
`default_nettype none
module uhp_modem #(
	parameter int CTS_DELAY = 8,
	parameter int HALF_BIT = 20,
	parameter logic FULL_DUPLEX = 1'b0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic dsr_on,
	input wire logic rts_n,
	input wire logic tx_data,
	output logic dsr_n,
	output logic cts_n,
	output logic bit_clock,
	output logic rx_data
);
	int wait_cnt;
	int div_cnt;
	assign dsr_n = !dsr_on;
	// Serial loopback keeps the test free of a second serial model
	assign rx_data = tx_data;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_cnt <= 0;
			div_cnt <= 0;
			cts_n <= 1'b1;
			bit_clock <= 1'b1;
		end else begin
			wait_cnt <= rts_n ? 0 : wait_cnt + 1;
			// Full duplex hands the request straight back, half duplex answers late
			if (FULL_DUPLEX) begin
				cts_n <= rts_n;
			end else begin
				cts_n <= rts_n || (wait_cnt < CTS_DELAY);
			end
			div_cnt <= (rts_n || div_cnt == HALF_BIT - 1) ? 0 : div_cnt + 1;
			// Bit clock stands still while no request is up
			if (rts_n) begin
				bit_clock <= 1'b1;
			end else if (div_cnt == HALF_BIT - 1) begin
				bit_clock <= !bit_clock;
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/uhp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uhp_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic cd,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic host_data_oe_n,
	input wire logic dtr_n,
	input wire logic rts_n,
	input wire logic tx_buffer_ready,
	input wire logic tx_shift_empty,
	input wire logic rx_char_ready_n
);
	// Ages saturate, so an old access never excuses a late change
	logic [3:0] wr_age_reg;
	logic [3:0] ctl_age_reg;
	logic [3:0] rd_age_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_age_reg <= 4'hF;
			ctl_age_reg <= 4'hF;
			rd_age_reg <= 4'hF;
		end else begin
			wr_age_reg <= (!cs_n && !wr_n && rd_n && !cd) ? 4'h0 :
				(wr_age_reg == 4'hF) ? 4'hF : wr_age_reg + 4'h1;
			ctl_age_reg <= (!cs_n && !wr_n && rd_n && cd) ? 4'h0 :
				(ctl_age_reg == 4'hF) ? 4'hF : ctl_age_reg + 4'h1;
			rd_age_reg <= (!cs_n && !rd_n && wr_n && !cd) ? 4'h0 :
				(rd_age_reg == 4'hF) ? 4'hF : rd_age_reg + 4'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_deselect_hiz: assert property (cs_n [*4] |-> host_data_oe_n)
		else $error("bus driven while deselected");
	a_read_drive: assert property ((!cs_n && !rd_n && wr_n) [*4] |-> !host_data_oe_n)
		else $error("read left bus undriven");
	a_write_quiet: assert property (rd_n [*4] |-> host_data_oe_n)
		else $error("bus driven without read");
	a_ready_drop: assert property ($fell(tx_buffer_ready) |-> wr_age_reg <= 4'h6)
		else $error("transmit ready fell without data write");
	a_load_pair: assert property ($rose(tx_buffer_ready) |-> $fell(tx_shift_empty))
		else $error("ready rose without shifter load");
	a_empty_hold: assert property ($fell(tx_shift_empty) |-> !$past(tx_buffer_ready))
		else $error("shifter loaded from empty buffer");
	a_link_gate: assert property ($fell(tx_shift_empty) |-> !dtr_n && !rts_n)
		else $error("transmit started without link");
	a_ctl_outputs: assert property ($changed(dtr_n) || $changed(rts_n) |-> ctl_age_reg <= 4'h6)
		else $error("modem output changed without control write");
	a_rx_clear: assert property ($rose(rx_char_ready_n) |-> rd_age_reg <= 4'h6)
		else $error("receive ready cleared without data read");
	c_tx_load: cover property ($rose(tx_buffer_ready));
	c_rx_char: cover property ($fell(rx_char_ready_n));
	c_bus_read: cover property ($fell(host_data_oe_n));
endmodule
bind uhp_usart uhp_checker i_chk (.clk(clk), .nrst(nrst), .cs_n(cs_n), .cd(cd), .rd_n(rd_n),
	.wr_n(wr_n), .host_data_oe_n(host_data_oe_n), .dtr_n(dtr_n), .rts_n(rts_n),
	.tx_buffer_ready(tx_buffer_ready), .tx_shift_empty(tx_shift_empty),
	.rx_char_ready_n(rx_char_ready_n));
`default_nettype wire
